//--- rtl/mbsrc_checker.sv
// Request checker, register store and loopback self-test of the MODBUS slave
`timescale 1ns/1ps
module mbsrc_checker
  import mbsrc_pkg::*;
#(
  parameter int PROC_WAIT = PROC_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Node configuration and drive state
  input wire logic [7:0] node_addr_i,
  input wire logic [7:0] input_s7_function_select_i,
  input wire logic drive_running_i,
  input wire logic nonvolatile_fault_alarm_i,
  input wire logic undervoltage_alarm_i,
  input wire logic [15:0] output_freq_i,
  // Character activity from the receiver
  input wire logic rx_char_i,
  // Decoded request
  input wire logic req_valid_i,
  input wire mbsrc_req_t req_i,
  output logic req_ready_o,
  // Write data words
  input wire logic wdata_valid_i,
  input wire logic [15:0] wdata_i,
  output logic wdata_ready_o,
  // Response beats
  output logic resp_valid_o,
  output mbsrc_resp_t resp_o,
  input wire logic resp_ready_i,
  // Register contents and status
  output logic [15:0] run_command_o,
  output logic [15:0] freq_ref_chz_o,
  output logic [15:0] skip_freq_one_o,
  output logic [15:0] freq_unit_o,
  output logic param_busy_o,
  output logic [7:0] last_exc_code_o,
  // Loopback self-test
  output logic loop_tx_o,
  input wire logic loop_rx_i,
  output logic selftest_pass_o,
  output logic comm_error_alarm_o,
  output logic fault_contact_o,
  output logic op_ready_o
);

  mbsrc_state_t state_r;
  mbsrc_req_t req_r;
  mbsrc_resp_t out_r;
  logic out_valid_r, bcast_r, final_r, frame_r, gap_err_r;
  logic [7:0] exc_r, last_exc_r;
  logic [15:0] cur_addr_r, left_r;
  logic [15:0] run_r, fref_r, skip_r, unit_r;
  logic [23:0] proc_cnt_r;
  logic [11:0] bit_cnt_r;
  logic [4:0] gap_cnt_r;
  logic rx_meta_r, rx_sync_r, tx_r;
  logic st_init_r, st_run_r, st_done_r, st_fail_r;
  logic [3:0] st_idx_r;

  // Bit-time enable and request header decode
  wire tick = bit_cnt_r == 12'(BIT_CYCLES - 1);
  wire take = req_valid_i && state_r == ST_IDLE;
  wire is_bc = req_i.slave_addr == BCAST_ADDR;
  wire f_rd = req_i.func == FC_READ;
  wire f_wr = req_i.func == FC_WRITE;
  wire f_lp = req_i.func == FC_LOOP;
  // A gap that runs out in the take cycle drops that frame too
  wire gap_over = frame_r && gap_cnt_r > GAP_BITS;
  wire drop = (|req_i.err) || gap_err_r || gap_over || (is_bc && !f_wr)
    || (!is_bc && req_i.slave_addr != node_addr_i);
  wire qty_bad = req_i.qty < QTY_MIN || req_i.qty > QTY_MAX;
  wire bcnt_bad = {8'h00, req_i.byte_cnt} != {req_i.qty[14:0], 1'b0};
  wire [7:0] hdr_exc = !(f_rd || f_wr || f_lp) ? EX_FUNC :
    ((f_rd || f_wr) && qty_bad) ? EX_QTY :
    (f_wr && bcnt_bad) ? EX_QTY : EX_NONE;
  wire is_write_r = req_r.func == FC_WRITE;
  wire is_loop_r = req_r.func == FC_LOOP;

  // Register address decode
  wire is_run = cur_addr_r == REG_RUN;
  wire is_fref = cur_addr_r == REG_FREF;
  wire is_fmon = cur_addr_r == REG_FREF_MON;
  wire is_omon = cur_addr_r == REG_OFREQ_MON;
  wire is_skip = cur_addr_r == REG_SKIP1;
  wire is_unit = cur_addr_r == REG_UNIT;
  wire is_cmt = cur_addr_r == REG_COMMIT_NV || cur_addr_r == REG_COMMIT_RAM;
  wire is_param = is_skip || is_unit;
  wire is_def = is_run || is_fref || is_fmon || is_omon || is_param || is_cmt;
  wire is_ro = is_fmon || is_omon;
  wire busy = proc_cnt_r != 24'h000000;
  wire unit_sel = unit_r != UNIT_RESET;

  // Address and permission checks, one register per cycle
  wire [7:0] rd_exc = (!is_def || is_cmt) ? EX_ADDR : EX_NONE;
  wire [7:0] wr_exc =
    bcast_r ? ((cur_addr_r <= REG_BCAST_LAST) ? EX_NONE : EX_ADDR) :
    !is_def ? EX_ADDR :
    is_ro ? EX_MODE :
    ((is_param || is_cmt) && drive_running_i) ? EX_MODE :
    (is_skip && nonvolatile_fault_alarm_i) ? EX_MODE :
    ((is_param || is_cmt) && undervoltage_alarm_i) ? EX_UV :
    (is_param && busy) ? EX_BUSY : EX_NONE;
  wire [7:0] scan_exc = is_write_r ? wr_exc : rd_exc;

  // Value conversion between wire units and 0.01 Hz
  wire [19:0] in_chz = unit_sel ? 20'(wdata_i) * 20'(UNIT_DIV) : 20'(wdata_i);
  wire [31:0] bc_chz = (32'(wdata_i) * 32'(MAX_FREQ_CHZ)) / 32'(BCAST_FULL_SCALE);
  wire fref_bad = bcast_r ? (wdata_i > BCAST_FULL_SCALE) : (in_chz > 20'(MAX_FREQ_CHZ));
  wire [15:0] fref_new = bcast_r ? bc_chz[15:0] : in_chz[15:0];
  // Limits compare unsigned where the register is unsigned
  wire [7:0] dat_exc = ((is_fref && fref_bad) || (is_skip && wdata_i > SKIP1_MAX)
    || (is_unit && wdata_i > UNIT_MAX) || (is_cmt && wdata_i != 16'h0000))
    ? EX_DATA : EX_NONE;
  wire [15:0] fref_u = unit_sel ? 16'(fref_r / UNIT_DIV) : fref_r;
  wire [15:0] ofreq_u = unit_sel ? 16'(output_freq_i / UNIT_DIV) : output_freq_i;
  wire [15:0] rd_word = is_run ? run_r : (is_fref || is_fmon) ? fref_u :
    is_omon ? ofreq_u : is_skip ? skip_r : is_unit ? unit_r : 16'h0000;

  // Handshakes
  wire wr_fire = state_r == ST_DATA && is_write_r && wdata_valid_i;
  wire rd_fire = state_r == ST_DATA && !is_write_r && !out_valid_r;
  wire fin_fire = state_r == ST_RESP && !out_valid_r && final_r;
  wire wr_ok = wr_fire && exc_r == EX_NONE && dat_exc == EX_NONE;
  wire last_word = left_r == 16'h0001;

  // Request sequencing
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      req_r <= '0;
      bcast_r <= 1'b0;
      final_r <= 1'b0;
      exc_r <= EX_NONE;
      last_exc_r <= EX_NONE;
      cur_addr_r <= 16'h0000;
      left_r <= 16'h0000;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (take && !drop) begin
            req_r <= req_i;
            bcast_r <= is_bc;
            exc_r <= hdr_exc;
            final_r <= !is_bc;
            cur_addr_r <= req_i.start;
            left_r <= req_i.qty;
            state_r <= (hdr_exc != EX_NONE || f_lp) ? ST_RESP : ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (scan_exc != EX_NONE) begin
            exc_r <= scan_exc;
            final_r <= !bcast_r;
            state_r <= ST_RESP;
          end else if (last_word) begin
            cur_addr_r <= req_r.start;
            left_r <= req_r.qty;
            final_r <= !bcast_r && is_write_r;
            state_r <= ST_DATA;
          end else begin
            cur_addr_r <= cur_addr_r + 16'h0001;
            left_r <= left_r - 16'h0001;
          end
        end
        ST_DATA: begin
          if (wr_fire || rd_fire) begin
            if (wr_fire && exc_r == EX_NONE && dat_exc != EX_NONE) begin
              exc_r <= dat_exc;
            end
            cur_addr_r <= cur_addr_r + 16'h0001;
            left_r <= left_r - 16'h0001;
            if (last_word) begin
              state_r <= ST_RESP;
            end
          end
        end
        ST_RESP: begin
          if (!out_valid_r) begin
            if (final_r) begin
              final_r <= 1'b0;
            end else begin
              state_r <= ST_IDLE;
              if (exc_r != EX_NONE) begin
                last_exc_r <= exc_r;
              end
            end
          end
        end
      endcase
    end
  end

  // Response beat register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      out_valid_r <= 1'b0;
      out_r <= '0;
    end else if (rd_fire) begin
      out_valid_r <= 1'b1;
      out_r <= '{1'b0, req_r.func, EX_NONE, rd_word, last_word};
    end else if (fin_fire) begin
      out_valid_r <= 1'b1;
      out_r.exc <= exc_r != EX_NONE;
      out_r.func <= (exc_r != EX_NONE) ? (req_r.func | FC_EXC_FLAG) : req_r.func;
      out_r.code <= exc_r;
      out_r.word <= is_loop_r ? req_r.start : req_r.qty;
      out_r.last <= 1'b1;
    end else if (resp_ready_i) begin
      out_valid_r <= 1'b0;
    end
  end

  // Register store and parameter processing timer
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      run_r <= RUN_RESET;
      fref_r <= FREF_RESET;
      skip_r <= SKIP1_RESET;
      unit_r <= UNIT_RESET;
      proc_cnt_r <= 24'h000000;
    end else begin
      if (wr_ok && is_run) run_r <= wdata_i & RUN_MASK;
      if (wr_ok && is_fref) fref_r <= fref_new;
      if (wr_ok && is_skip) skip_r <= wdata_i;
      if (wr_ok && is_unit) unit_r <= wdata_i;
      if (wr_ok && is_cmt) begin
        proc_cnt_r <= 24'(PROC_WAIT);
      end else if (busy) begin
        proc_cnt_r <= proc_cnt_r - 24'h000001;
      end
    end
  end

  // Bit-time divider and inter-character gap watch
  always_ff @(posedge core_clk_i) begin
    if (reset_i || tick) begin
      bit_cnt_r <= 12'h000;
    end else begin
      bit_cnt_r <= bit_cnt_r + 12'h001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      frame_r <= 1'b0;
      gap_cnt_r <= 5'h00;
      gap_err_r <= 1'b0;
    end else begin
      if (take) begin
        frame_r <= 1'b0;
        gap_err_r <= 1'b0;
      end
      if (rx_char_i) begin
        frame_r <= 1'b1;
        gap_cnt_r <= 5'h00;
      end else if (frame_r && tick && gap_cnt_r <= GAP_BITS) begin
        gap_cnt_r <= gap_cnt_r + 5'h01;
      end
      if (gap_over && !take) begin
        gap_err_r <= 1'b1;
      end
    end
  end

  // Loopback self-test after reset release
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= loop_rx_i;
      rx_sync_r <= rx_meta_r;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_init_r <= 1'b1;
      st_run_r <= 1'b0;
      st_done_r <= 1'b0;
      st_fail_r <= 1'b0;
      st_idx_r <= 4'h0;
      tx_r <= 1'b1;
    end else begin
      st_init_r <= 1'b0;
      if (st_init_r) begin
        st_run_r <= input_s7_function_select_i == TEST_MODE_SEL;
      end else if (st_run_r && tick) begin
        if (st_idx_r != 4'h0 && rx_sync_r != tx_r) begin
          st_fail_r <= 1'b1;
        end
        tx_r <= st_idx_r[3] ? 1'b1 : SELFTEST_PATTERN[st_idx_r[2:0]];
        st_idx_r <= st_idx_r + 4'h1;
        if (st_idx_r[3]) begin
          st_run_r <= 1'b0;
          st_done_r <= 1'b1;
        end
      end
    end
  end

  // Outputs
  assign req_ready_o = state_r == ST_IDLE;
  assign wdata_ready_o = state_r == ST_DATA && is_write_r;
  assign resp_valid_o = out_valid_r;
  assign resp_o = out_r;
  assign run_command_o = run_r;
  assign freq_ref_chz_o = fref_r;
  assign skip_freq_one_o = skip_r;
  assign freq_unit_o = unit_r;
  assign param_busy_o = busy;
  assign last_exc_code_o = last_exc_r;
  assign loop_tx_o = tx_r;
  assign selftest_pass_o = st_done_r && !st_fail_r;
  assign comm_error_alarm_o = st_fail_r;
  assign fault_contact_o = st_fail_r;
  assign op_ready_o = !st_init_r && !st_run_r && !st_fail_r;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  a_link_drop: assert property ((take && |req_i.err) |=> state_r == ST_IDLE && !out_valid_r)
    else $error("link-error frame was not dropped");
  a_node_drop: assert property ((take && !is_bc && req_i.slave_addr != node_addr_i)
    |=> state_r == ST_IDLE ##1 !out_valid_r)
    else $error("frame for another node was accepted");
  a_func_exc: assert property ((take && !drop && !(f_rd || f_wr || f_lp))
    |=> exc_r == EX_FUNC ##1 out_valid_r && out_r.code == EX_FUNC)
    else $error("bad function code not answered with 01");
  a_qty_exc: assert property ((take && !drop && f_rd && qty_bad) |=> exc_r == EX_QTY)
    else $error("bad quantity not flagged with 03");
  a_commit_read: assert property ((state_r == ST_SCAN && !is_write_r && is_cmt)
    |=> exc_r == EX_ADDR && state_r == ST_RESP)
    else $error("commit register read not refused");
  a_busy_refuse: assert property ((state_r == ST_SCAN && is_write_r && !bcast_r && is_skip
    && busy && !drive_running_i && !nonvolatile_fault_alarm_i && !undervoltage_alarm_i)
    |=> exc_r == EX_BUSY)
    else $error("write during processing not refused with 24");
  a_bcast_quiet: assert property (bcast_r && state_r != ST_IDLE |-> !out_valid_r)
    else $error("broadcast produced a response");
  a_exc_format: assert property ((out_valid_r && out_r.exc)
    |-> out_r.func[7] && out_r.code == exc_r && out_r.last)
    else $error("exception beat malformed");
  a_run_zero: assert property ((wr_ok && is_run) |=> run_r[15:11] == 5'h00)
    else $error("run command unused bits not zero");
  a_fail_outputs: assert property ($rose(st_fail_r)
    |-> comm_error_alarm_o && fault_contact_o && !op_ready_o)
    else $error("self-test failure outputs wrong");

endmodule

//--- rtl/mbsrc_pkg.sv
// Constants and carrier types for the MODBUS slave request checker
package mbsrc_pkg;
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam logic [4:0] GAP_BITS = 5'h18;
  localparam int PROC_TIME_US = 1000;
  localparam int PROC_CYCLES = (CLK_HZ / 1_000_000) * PROC_TIME_US;

  // Function codes and exception codes
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_LOOP = 8'h08;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EX_NONE = 8'h00;
  localparam logic [7:0] EX_FUNC = 8'h01;
  localparam logic [7:0] EX_ADDR = 8'h02;
  localparam logic [7:0] EX_QTY = 8'h03;
  localparam logic [7:0] EX_DATA = 8'h21;
  localparam logic [7:0] EX_MODE = 8'h22;
  localparam logic [7:0] EX_UV = 8'h23;
  localparam logic [7:0] EX_BUSY = 8'h24;

  // Addressing, quantities, self-test select and pattern
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] QTY_MIN = 16'h0001;
  localparam logic [15:0] QTY_MAX = 16'h0010;
  localparam logic [7:0] TEST_MODE_SEL = 8'h43;
  localparam logic [7:0] SELFTEST_PATTERN = 8'h5a;

  // Register map
  localparam logic [15:0] REG_RUN = 16'h0001;
  localparam logic [15:0] REG_FREF = 16'h0002;
  localparam logic [15:0] REG_FREF_MON = 16'h0023;
  localparam logic [15:0] REG_OFREQ_MON = 16'h0024;
  localparam logic [15:0] REG_SKIP1 = 16'h0294;
  localparam logic [15:0] REG_UNIT = 16'h0502;
  localparam logic [15:0] REG_COMMIT_NV = 16'h0900;
  localparam logic [15:0] REG_COMMIT_RAM = 16'h0910;
  localparam logic [15:0] REG_BCAST_LAST = 16'h0002;

  // Reset values, field masks and limits
  localparam logic [15:0] RUN_RESET = 16'h0000;
  localparam logic [15:0] FREF_RESET = 16'h0000;
  localparam logic [15:0] SKIP1_RESET = 16'h0000;
  localparam logic [15:0] UNIT_RESET = 16'h0000;
  localparam logic [15:0] RUN_MASK = 16'h07ff;
  localparam logic [15:0] SKIP1_MAX = 16'h9c40;
  localparam logic [15:0] UNIT_MAX = 16'h0001;
  localparam logic [15:0] UNIT_DIV = 16'h000a;
  localparam logic [15:0] MAX_FREQ_CHZ = 16'h1770;
  localparam logic [15:0] BCAST_FULL_SCALE = 16'h7530;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_DATA = 2'b11,
    ST_RESP = 2'b10
  } mbsrc_state_t;

  typedef struct packed {
    logic overrun;
    logic framing;
    logic parity;
    logic crc;
    logic bad_len;
  } mbsrc_link_err_t;

  typedef struct packed {
    logic [7:0] slave_addr;
    logic [7:0] func;
    logic [15:0] start;
    logic [15:0] qty;
    logic [7:0] byte_cnt;
    mbsrc_link_err_t err;
  } mbsrc_req_t;

  typedef struct packed {
    logic exc;
    logic [7:0] func;
    logic [7:0] code;
    logic [15:0] word;
    logic last;
  } mbsrc_resp_t;
endpackage

//--- tb/mbsrc_master_model.sv
// Master-side partner: response acceptance with stalls, loopback wiring
`timescale 1ns/1ps
module mbsrc_master_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Response acceptance
  input wire logic slow_i,
  output logic resp_ready_o,
  // Loopback terminals
  input wire logic loop_tx_i,
  input wire logic loop_break_i,
  output logic loop_rx_o
);
  logic [1:0] cnt_r = 2'h0;
  // Stalled master is ready one cycle in four
  always @(negedge core_clk_i) begin
    cnt_r <= reset_i ? 2'h0 : cnt_r + 2'h1;
    resp_ready_o <= !slow_i || (cnt_r == 2'h0);
  end
  // A broken loop inverts the wire so every returned bit is wrong
  assign loop_rx_o = loop_break_i ? !loop_tx_i : loop_tx_i;
endmodule

//--- tb/tb_modbus_slave_request_checker.sv
// Self-checking bench for the MODBUS slave request checker
`timescale 1ns/1ps
module tb_modbus_slave_request_checker;
  import mbsrc_pkg::*;
  localparam logic [7:0] NODE = 8'h11;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic run = 1'b0, nvf = 1'b0, uv = 1'b0, slow = 1'b0, brk = 1'b0;
  logic rx_char = 1'b0;
  logic [7:0] s7 = TEST_MODE_SEL;
  logic [15:0] ofreq = 16'h04d2;
  logic req_valid = 1'b0, wvalid = 1'b0;
  mbsrc_req_t req = '0;
  logic [15:0] wdata = 16'h0000;
  logic req_ready, wready, resp_valid, resp_ready, loop_tx, loop_rx;
  mbsrc_resp_t resp;
  logic [15:0] run_w, fref, skip, unit;
  logic busy, st_pass, ce_alarm, fault, op_ready;
  logic [7:0] last_exc;
  mbsrc_resp_t q[$];
  logic [15:0] wq[$];
  int num_errors = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'd46;

  mbsrc_checker #(.PROC_WAIT(40)) i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .node_addr_i(NODE), .input_s7_function_select_i(s7),
    .drive_running_i(run), .nonvolatile_fault_alarm_i(nvf), .undervoltage_alarm_i(uv),
    .output_freq_i(ofreq), .rx_char_i(rx_char), .req_valid_i(req_valid), .req_i(req),
    .req_ready_o(req_ready), .wdata_valid_i(wvalid), .wdata_i(wdata),
    .wdata_ready_o(wready), .resp_valid_o(resp_valid), .resp_o(resp),
    .resp_ready_i(resp_ready), .run_command_o(run_w), .freq_ref_chz_o(fref),
    .skip_freq_one_o(skip), .freq_unit_o(unit), .param_busy_o(busy),
    .last_exc_code_o(last_exc), .loop_tx_o(loop_tx), .loop_rx_i(loop_rx),
    .selftest_pass_o(st_pass), .comm_error_alarm_o(ce_alarm), .fault_contact_o(fault),
    .op_ready_o(op_ready));
  mbsrc_master_model i_master (.core_clk_i(core_clk_i), .reset_i(reset_i), .slow_i(slow),
    .resp_ready_o(resp_ready), .loop_tx_i(loop_tx), .loop_break_i(brk),
    .loop_rx_o(loop_rx));

  initial forever #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (resp_valid === 1'b1 && resp_ready === 1'b1) q.push_back(resp);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exc_fc(input logic [7:0] fc);
    return fc | FC_EXC_FLAG;
  endfunction
  // Broadcast reference is full scale at 30000, fraction truncated
  function automatic logic [15:0] exp_bc(input logic [15:0] v);
    return 16'((32'(v) * 32'(MAX_FREQ_CHZ)) / 32'(BCAST_FULL_SCALE));
  endfunction
  task automatic summarize();
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, then its queued words, then collect nb response beats
  task automatic send(input logic [7:0] sa, input logic [7:0] fc, input logic [15:0] st,
      input logic [15:0] qt, input logic [7:0] bc, input mbsrc_link_err_t er, input int nb);
    int i;
    q.delete();
    @(negedge core_clk_i);
    req_valid = 1'b1;
    req = '{sa, fc, st, qt, bc, er};
    // Ready is settled at the falling edge, so the next rising edge takes the request
    for (i = 0; req_ready !== 1'b1 && i < 500; i++) @(negedge core_clk_i);
    if (i >= 500) num_errors++;
    @(negedge core_clk_i);
    req_valid = 1'b0;
    // Words are offered only in the word phase; an early answer or a drop ends it
    while (wq.size() > 0) begin
      for (i = 0; wready !== 1'b1 && req_ready !== 1'b1 && i < 500; i++) @(negedge core_clk_i);
      if (i >= 500) num_errors++;
      wdata = wq.pop_front();
      if (wready === 1'b1) begin
        wvalid = 1'b1;
        @(negedge core_clk_i);
      end
    end
    if (wvalid) wvalid = 1'b0;
    for (i = 0; i < 300 && q.size() < nb; i++) @(posedge core_clk_i);
    repeat (nb == 0 ? 30 : 3) @(posedge core_clk_i);
    chk(q.size(), nb);
    @(negedge core_clk_i);
  endtask
  task automatic exc(input logic [7:0] fc, input logic [15:0] st, input logic [15:0] qt,
      input logic [7:0] bc, input logic [7:0] code);
    send(NODE, fc, st, qt, bc, '0, 1);
    chk({q[0].exc, q[0].last, q[0].func, q[0].code}, {2'b11, exc_fc(fc), code});
  endtask
  task automatic wr(input logic [15:0] st, input logic [15:0] v);
    wq.push_back(v);
    send(NODE, FC_WRITE, st, 16'h1, 8'h2, '0, 1);
    chk({q[0].exc, q[0].word}, 17'h00001);
  endtask
  task automatic rd(input logic [15:0] st, input logic [15:0] qt);
    send(NODE, FC_READ, st, qt, 8'h0, '0, int'(qt));
  endtask

  initial begin
    #(95000 * 40);
    num_errors++;
    summarize();
  end

  initial begin
    logic [31:0] t;
    logic [15:0] v;
    logic [15:0] ef;
    repeat (4) @(negedge core_clk_i);
    reset_i = 1'b0;
    rx_char = 1'b1;
    @(negedge core_clk_i);
    rx_char = 1'b0;
    for (int i = 0; i < 30000 && st_pass !== 1'b1; i++) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk({st_pass, ce_alarm, fault}, 3'b100);
    // The frame opened by the pulse has now idled well past 24 bit times
    repeat (17 * BIT_CYCLES) @(negedge core_clk_i);
    send(NODE, FC_READ, REG_UNIT, 16'h1, 8'h0, '0, 0);
    send(NODE, FC_READ, REG_UNIT, 16'h1, 8'h0, '0, 1);
    chk(q[0].word, UNIT_RESET);
    foreach (t[i]) if (i < 3) exc(8'h07 << i, REG_RUN, 16'h1, 8'h0, EX_FUNC);
    send(NODE, FC_LOOP, 16'h1234, 16'h1, 8'h0, '0, 1);
    chk({q[0].exc, q[0].word}, {1'b0, 16'h1234});
    exc(FC_READ, 16'h0100, 16'h1, 8'h0, EX_ADDR);
    exc(FC_READ, REG_COMMIT_NV, 16'h1, 8'h0, EX_ADDR);
    exc(FC_READ, REG_COMMIT_RAM, 16'h1, 8'h0, EX_ADDR);
    exc(FC_READ, REG_RUN, 16'h0, 8'h0, EX_QTY);
    exc(FC_READ, REG_RUN, 16'h11, 8'h0, EX_QTY);
    exc(FC_WRITE, REG_FREF, 16'h1, 8'h3, EX_QTY);
    wq.push_back(16'h0002);
    exc(FC_WRITE, REG_UNIT, 16'h1, 8'h2, EX_DATA);
    wq.push_back(16'h0001);
    exc(FC_WRITE, REG_FREF_MON, 16'h1, 8'h2, EX_MODE);
    run = 1'b1;
    wq.push_back(16'h0010);
    exc(FC_WRITE, REG_SKIP1, 16'h1, 8'h2, EX_MODE);
    run = 1'b0;
    nvf = 1'b1;
    wq.push_back(16'h0010);
    exc(FC_WRITE, REG_SKIP1, 16'h1, 8'h2, EX_MODE);
    wr(REG_UNIT, 16'h0000);
    nvf = 1'b0;
    uv = 1'b1;
    wq.push_back(16'h0010);
    exc(FC_WRITE, REG_SKIP1, 16'h1, 8'h2, EX_UV);
    uv = 1'b0;
    wr(REG_COMMIT_RAM, 16'h0000);
    chk(busy, 1'b1);
    wq.push_back(16'h0010);
    exc(FC_WRITE, REG_SKIP1, 16'h1, 8'h2, EX_BUSY);
    repeat (60) @(negedge core_clk_i);
    wr(REG_RUN, 16'hffff);
    chk(run_w, RUN_MASK);
    rd(REG_RUN, 16'h1);
    chk(q[0].word, RUN_MASK);
    for (int k = 0; k < 5; k++) begin
      t = rnd();
      slow = t[16];
      v = (k == 0) ? SKIP1_MAX : 16'(t % 32'd40001);
      wr(REG_SKIP1, v);
      rd(REG_SKIP1, 16'h1);
      chk(q[0].word, v);
      chk(skip, v);
    end
    slow = 1'b0;
    wq.push_back(SKIP1_MAX + 16'h1);
    exc(FC_WRITE, REG_SKIP1, 16'h1, 8'h2, EX_DATA);
    wq.push_back(BCAST_FULL_SCALE);
    send(BCAST_ADDR, FC_WRITE, REG_FREF, 16'h1, 8'h2, '0, 0);
    chk(fref, MAX_FREQ_CHZ);
    ef = exp_bc(16'd15001);
    wq.push_back(16'd15001);
    send(BCAST_ADDR, FC_WRITE, REG_FREF, 16'h1, 8'h2, '0, 0);
    chk(fref, ef);
    wq.push_back(16'h0001);
    send(BCAST_ADDR, FC_WRITE, 16'h0003, 16'h1, 8'h2, '0, 0);
    chk(last_exc, EX_ADDR);
    wr(REG_UNIT, UNIT_MAX);
    chk(unit, UNIT_MAX);
    rd(REG_FREF, 16'h1);
    chk(q[0].word, ef / UNIT_DIV);
    ofreq = 16'(rnd() % 32'd6001);
    rd(REG_FREF_MON, 16'h2);
    chk({q[0].word, q[1].word, q[1].last}, {ef / UNIT_DIV, ofreq / UNIT_DIV, 1'b1});
    rd(REG_SKIP1, 16'h1);
    chk(q[0].word, v);
    for (int b = 0; b < 5; b++) send(NODE, FC_READ, REG_UNIT, 16'h1, 8'h0, 5'(1 << b), 0);
    send(NODE, FC_READ, REG_UNIT, 16'h1, 8'h0, '0, 1);
    chk(q[0].word, UNIT_MAX);
    send(NODE ^ 8'h01, FC_READ, REG_UNIT, 16'h1, 8'h0, '0, 0);
    reset_i = 1'b1;
    brk = 1'b1;
    repeat (4) @(negedge core_clk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 30000 && ce_alarm !== 1'b1; i++) @(posedge core_clk_i);
    repeat (3) @(negedge core_clk_i);
    chk({st_pass, ce_alarm, fault, op_ready}, 4'b0110);
    // Without the test-mode select no loop test runs and the drive is ready at once
    reset_i = 1'b1;
    s7 = 8'h00;
    repeat (4) @(negedge core_clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk({st_pass, ce_alarm, fault, op_ready}, 4'b0001);
    summarize();
  end
endmodule
